/* dic_country_map.sv */
// Country profile to line interface byte mapper, purely combinational.
// Assumes the profile is held steady while a load is in progress.
module dic_country_map (
   dic_map_if.mapper m   // Profile in, register bytes out
);
   wire logic       nam_w;
   wire logic       ctr_w;
   wire logic       aus_w;
   wire logic       plsi_w;
   wire logic       zaf_w;
   wire logic       nzl_w;
   wire logic       bgr_w;
   wire logic [1:0] dcm_w;
   wire logic       spd_w;
   wire logic       acz_w;
   wire logic       rgi_w;
   wire logic       rth_w;
   wire logic       ilm_w;

   // Profile decode
   assign nam_w  = (m.profile == dic_pkg::PRF_NAM);
   assign ctr_w  = (m.profile == dic_pkg::PRF_CTR);
   assign aus_w  = (m.profile == dic_pkg::PRF_AUS);
   assign plsi_w = (m.profile == dic_pkg::PRF_PLSI);
   assign zaf_w  = (m.profile == dic_pkg::PRF_ZAF);
   assign nzl_w  = (m.profile == dic_pkg::PRF_NZL);
   assign bgr_w  = (m.profile == dic_pkg::PRF_BGR);

   // Dc termination mode per group; low-voltage group falls through
   assign dcm_w = (nam_w | plsi_w | zaf_w | nzl_w) ?
                     dic_pkg::DCM_FCC :
                  (ctr_w | bgr_w) ? dic_pkg::DCM_CTR :
                  dic_pkg::DCM_JAPAN;

   // Remaining fields; ac term is software choice only for CTR group
   assign spd_w = aus_w | zaf_w;
   assign acz_w = aus_w | nzl_w | bgr_w |
                  (ctr_w & m.acz_opt);
   assign rgi_w = plsi_w | zaf_w;
   assign rth_w = plsi_w;
   assign ilm_w = ctr_w | bgr_w;

   // Byte assembly
   assign m.lic_a = (8'(spd_w) << dic_pkg::F_SPD) |
                    (8'(acz_w) << dic_pkg::F_ACZ) |
                    (8'(dcm_w) << dic_pkg::F_DCM) |
                    (8'(rgi_w) << dic_pkg::F_RGI) |
                    (8'(rth_w) << dic_pkg::F_RTH);
   assign m.lic_b = 8'(ilm_w) << dic_pkg::F_ILM;
   assign m.lic_c = dic_pkg::VADJ_ZERO;
endmodule

/* dic_dev_model.sv */
// Behavioural line-side device behind the controller's register port.
// Assumes one write per strobe cycle, sampled on the host clock.
module dic_dev_model #(
   parameter int         LOCK_CYC = 20,   // Clocks until PLL lock
   parameter int         PWD_BIT  = 4,    // Power-down bit, arbitrary
   parameter logic [7:0] CTL2_RST = 8'h10 // Arbitrary, link off
) (
   input  wire logic       clk_i,     // Host clock
   input  wire logic       rst_n_i,   // Sync reset, active low
   input  wire logic       wr_i,      // Write strobe
   input  wire logic [7:0] addr_i,    // Register address
   input  wire logic [7:0] wdata_i,   // Write data
   output      logic [7:0] lic_a_o,   // Line control byte a
   output      logic [7:0] lic_b_o,   // Line control byte b
   output      logic [7:0] lic_c_o,   // Line control byte c
   output      logic       powered_o, // Line side powered
   output      logic       ready_o,   // Ring detect and off-hook usable
   output      int         err_o      // Out-of-order writes seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl2_q;
   logic [2:0] loaded_q;
   int         lock_q;
   logic       line_wr;
   logic       bad;
   // Link and line side come up only once power-down is cleared
   assign powered_o = !ctl2_q[PWD_BIT];
   assign ready_o   = powered_o && (loaded_q == 3'h7);
   // Lock still running, or line fields sent over a dead link
   assign line_wr = wr_i && (addr_i[7:4] == 4'h1);
   assign bad = wr_i && ((addr_i == dic_pkg::DEV_CTL2 && lock_q != 0)
                || (line_wr && !powered_o));
   // Register file; line writes are lost while the link is down
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctl2_q   <= CTL2_RST;
         lock_q   <= 0;
         loaded_q <= 3'h0;
         err_o    <= 0;
      end else begin
         err_o <= err_o + (bad ? 1 : 0);
         if (wr_i && addr_i == dic_pkg::DEV_SRATE)
            lock_q <= LOCK_CYC;
         else if (lock_q > 0)
            lock_q <= lock_q - 1;
         if (wr_i && addr_i == dic_pkg::DEV_CTL2)
            ctl2_q <= wdata_i;
         if (line_wr && powered_o) begin
            loaded_q[addr_i[1:0]] <= 1'b1;
            if (addr_i == dic_pkg::DEV_LIC_A) lic_a_o <= wdata_i;
            if (addr_i == dic_pkg::DEV_LIC_B) lic_b_o <= wdata_i;
            if (addr_i == dic_pkg::DEV_LIC_C) lic_c_o <= wdata_i;
         end
      end
   end
endmodule

/* dic_init_ctrl.sv */
// Host-side start-up sequencer and country loader for the line interface,
// with an AXI4-Lite register slave for software.
// Assumes the device takes one register write per strobe cycle.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module dic_init_ctrl #(
   parameter int LOCK_WAIT_CYC = dic_pkg::LOCK_WAIT_CYC
) (
   input  wire logic        CLK_I,          // 25 MHz clock
   input  wire logic        RST_N_I,        // Sync reset, active low
   input  wire logic [4:0]  AWADDR_I,       // Write address
   input  wire logic        AWVALID_I,      // Write address valid
   output      logic        AWREADY_O,      // Write address ready
   input  wire logic [31:0] WDATA_I,        // Write data
   input  wire logic [3:0]  WSTRB_I,        // Write byte strobes
   input  wire logic        WVALID_I,       // Write data valid
   output      logic        WREADY_O,       // Write data ready
   output      logic [1:0]  BRESP_O,        // Write response
   output      logic        BVALID_O,       // Write response valid
   input  wire logic        BREADY_I,       // Write response ready
   input  wire logic [4:0]  ARADDR_I,       // Read address
   input  wire logic        ARVALID_I,      // Read address valid
   output      logic        ARREADY_O,      // Read address ready
   output      logic [31:0] RDATA_O,        // Read data
   output      logic [1:0]  RRESP_O,        // Read response
   output      logic        RVALID_O,       // Read data valid
   input  wire logic        RREADY_I,       // Read data ready
   output      logic        DEV_WR_O,       // Device write strobe
   output      logic [7:0]  DEV_ADDR_O,     // Device register address
   output      logic [7:0]  DEV_WDATA_O,    // Device write data
   output      logic        LINE_READY_O,   // Sequence complete
   output      logic        OFFHOOK_REQ_O   // Gated off-hook request
);
   dic_map_if mif ();

   logic [4:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        awready_q;
   logic        wready_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        arready_q;
   logic        rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic [2:0]  profile_q;
   logic        acz_opt_q;
   logic [7:0]  srate_q;
   logic        offhk_q;
   logic        link_up_q;
   dic_pkg::dic_state_t st_q;
   dic_pkg::dic_state_t st_d;
   logic [14:0] lock_cnt_q;
   logic        dev_wr_q;
   logic [7:0]  dev_addr_q;
   logic [7:0]  dev_wdata_q;
   logic        ready_q;
   logic        offhk_out_q;
   logic [15:0] gap_q;

   wire logic        do_wr;
   wire logic        do_rd;
   wire logic        w_ctrl;
   wire logic        w_prof;
   wire logic        w_srate;
   wire logic        w_stat;
   wire logic        w_map;
   wire logic        r_map;
   wire logic        busy_w;
   wire logic        start_w;
   wire logic        lock_end;
   wire logic        wr_st;
   wire logic [7:0]  addr_w;
   wire logic [7:0]  data_w;
   wire logic [31:0] rd_w;
   wire logic [31:0] status_w;
   wire logic        lia_wr;

   assign mif.profile = profile_q;
   assign mif.acz_opt = acz_opt_q;

   dic_country_map u_map (
      .m (mif.mapper)
   );

   // Write path: both halves captured, then applied once
   assign do_wr   = !awready_q && !wready_q && !bvalid_q;
   assign w_ctrl  = (awaddr_q == dic_pkg::OFS_CTRL);
   assign w_prof  = (awaddr_q == dic_pkg::OFS_PROFILE);
   assign w_srate = (awaddr_q == dic_pkg::OFS_SRATE);
   assign w_stat  = (awaddr_q == dic_pkg::OFS_STATUS);
   assign w_map   = w_ctrl || w_prof || w_srate || w_stat;
   assign busy_w  = (st_q != dic_pkg::S_IDLE) && (st_q != dic_pkg::S_DONE);
   assign start_w = do_wr && w_ctrl && wstrb_q[0] &&
                    wdata_q[dic_pkg::CTRL_START] && !busy_w;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= dic_pkg::RESP_OKAY;
         awaddr_q  <= 5'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (AWVALID_I && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q  <= AWADDR_I;
         end
         if (WVALID_I && wready_q) begin
            wready_q <= 1'b0;
            wdata_q  <= WDATA_I;
            wstrb_q  <= WSTRB_I;
         end
         if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_map ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
         end else if (bvalid_q && BREADY_I) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Software registers; profile and rate frozen while loading
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         profile_q <= dic_pkg::PRF_NAM;
         acz_opt_q <= 1'b0;
         srate_q   <= dic_pkg::SRATE_RST;
         offhk_q   <= 1'b0;
      end else if (do_wr && wstrb_q[0]) begin
         if (w_ctrl)
            offhk_q <= wdata_q[dic_pkg::CTRL_OFFHK];
         if (w_prof && !busy_w) begin
            profile_q <= wdata_q[2:0];
            acz_opt_q <= wdata_q[dic_pkg::PROF_ACZ];
         end
         if (w_srate && !busy_w)
            srate_q <= wdata_q[7:0];
      end
   end

   // Read path
   assign do_rd    = ARVALID_I && arready_q;
   assign status_w = {26'h0, link_up_q, 3'(st_q) == 3'h0 ? 1'b0 : 1'b1,
                      ready_q, busy_w, 2'h0} >> 2;
   assign r_map    = (ARADDR_I == dic_pkg::OFS_CTRL) ||
                     (ARADDR_I == dic_pkg::OFS_PROFILE) ||
                     (ARADDR_I == dic_pkg::OFS_SRATE) ||
                     (ARADDR_I == dic_pkg::OFS_STATUS);
   assign rd_w = (ARADDR_I == dic_pkg::OFS_CTRL) ?
                    32'(offhk_q) << dic_pkg::CTRL_OFFHK :
                 (ARADDR_I == dic_pkg::OFS_PROFILE) ?
                    {28'h0, acz_opt_q, profile_q} :
                 (ARADDR_I == dic_pkg::OFS_SRATE) ? {24'h0, srate_q} :
                 (ARADDR_I == dic_pkg::OFS_STATUS) ? status_w :
                 32'h0000_0000;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= dic_pkg::RESP_OKAY;
      end else if (do_rd) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_w;
         rresp_q   <= r_map ? dic_pkg::RESP_OKAY : dic_pkg::RESP_SLVERR;
      end else if (rvalid_q && RREADY_I) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // Start-up sequence; nothing is written to the device before start
   assign lock_end = (lock_cnt_q == 15'(LOCK_WAIT_CYC - 1));
   always_comb begin
      st_d = st_q;
      case (st_q)
         dic_pkg::S_IDLE,
         dic_pkg::S_DONE: if (start_w) st_d = dic_pkg::S_SRATE;
         dic_pkg::S_SRATE: st_d = dic_pkg::S_LOCK;
         dic_pkg::S_LOCK: if (lock_end) st_d = dic_pkg::S_CTL2;
         dic_pkg::S_CTL2: st_d = dic_pkg::S_LIA;
         dic_pkg::S_LIA: st_d = dic_pkg::S_LIB;
         dic_pkg::S_LIB: st_d = dic_pkg::S_LIC;
         dic_pkg::S_LIC: st_d = dic_pkg::S_DONE;
         default: st_d = dic_pkg::S_IDLE;
      endcase
   end

   // Lock timer counts only while waiting
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         lock_cnt_q <= 15'h0000;
      else if (st_q == dic_pkg::S_LOCK)
         lock_cnt_q <= lock_cnt_q + 15'h0001;
      else
         lock_cnt_q <= 15'h0000;
   end

   // Device write selection, one register per write state
   assign wr_st  = (st_q == dic_pkg::S_SRATE) || (st_q == dic_pkg::S_CTL2) ||
                   (st_q == dic_pkg::S_LIA) || (st_q == dic_pkg::S_LIB) ||
                   (st_q == dic_pkg::S_LIC);
   assign addr_w = (st_q == dic_pkg::S_SRATE) ? dic_pkg::DEV_SRATE :
                   (st_q == dic_pkg::S_CTL2)  ? dic_pkg::DEV_CTL2 :
                   (st_q == dic_pkg::S_LIA)   ? dic_pkg::DEV_LIC_A :
                   (st_q == dic_pkg::S_LIB)   ? dic_pkg::DEV_LIC_B :
                   dic_pkg::DEV_LIC_C;
   assign data_w = (st_q == dic_pkg::S_SRATE) ? srate_q :
                   (st_q == dic_pkg::S_CTL2)  ? dic_pkg::CTL2_POWER_UP :
                   (st_q == dic_pkg::S_LIA)   ? mif.lic_a :
                   (st_q == dic_pkg::S_LIB)   ? mif.lic_b :
                   mif.lic_c;

   // Registered outputs; off-hook held back until the load is done
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         st_q        <= dic_pkg::S_IDLE;
         dev_wr_q    <= 1'b0;
         dev_addr_q  <= 8'h00;
         dev_wdata_q <= 8'h00;
         ready_q     <= 1'b0;
         offhk_out_q <= 1'b0;
         link_up_q   <= 1'b0;
      end else begin
         st_q        <= st_d;
         dev_wr_q    <= wr_st;
         dev_addr_q  <= wr_st ? addr_w : dev_addr_q;
         dev_wdata_q <= wr_st ? data_w : dev_wdata_q;
         ready_q     <= (st_q == dic_pkg::S_DONE);
         offhk_out_q <= offhk_q && (st_q == dic_pkg::S_DONE);
         if (st_q == dic_pkg::S_CTL2)
            link_up_q <= 1'b1;
      end
   end

   assign AWREADY_O     = awready_q;
   assign WREADY_O      = wready_q;
   assign BVALID_O      = bvalid_q;
   assign BRESP_O       = bresp_q;
   assign ARREADY_O     = arready_q;
   assign RVALID_O      = rvalid_q;
   assign RDATA_O       = rdata_q;
   assign RRESP_O       = rresp_q;
   assign DEV_WR_O      = dev_wr_q;
   assign DEV_ADDR_O    = dev_addr_q;
   assign DEV_WDATA_O   = dev_wdata_q;
   assign LINE_READY_O  = ready_q;
   assign OFFHOOK_REQ_O = offhk_out_q;

   // Cycles since the last sample rate write, for the lock check only
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         gap_q <= 16'h0000;
      else if (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_SRATE)
         gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF)
         gap_q <= gap_q + 16'h0001;
   end

   // First line byte strobe, shared by the country checks
   assign lia_wr = DEV_WR_O && (DEV_ADDR_O == dic_pkg::DEV_LIC_A);

   default clocking dcb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_srate_first: assert property (
      start_w |=> ##1 (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_SRATE))
      else $error("sample rate not written first");
   a_lock_wait: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_CTL2) |->
         gap_q == 16'(LOCK_WAIT_CYC))
      else $error("control two written before lock time");
   a_ctl2_zero: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_CTL2) |->
         DEV_WDATA_O == dic_pkg::CTL2_POWER_UP)
      else $error("control two not written with zero");
   a_line_order: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_CTL2) |=>
         (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_A) ##1
         (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_B) ##1
         (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_C))
      else $error("line fields not loaded in order");
   a_vol_zero: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_C) |-> DEV_WDATA_O == 8'h00)
      else $error("voltage adjust not zero");
   a_nam_dct: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_A &&
       profile_q == dic_pkg::PRF_NAM) |-> DEV_WDATA_O == 8'h08)
      else $error("north american profile value wrong");
   a_lim_group: assert property (
      (DEV_WR_O && DEV_ADDR_O == dic_pkg::DEV_LIC_B) |->
         DEV_WDATA_O[dic_pkg::F_ILM] == (profile_q == dic_pkg::PRF_CTR ||
                                          profile_q == dic_pkg::PRF_BGR))
      else $error("current limit wrong for profile");
   a_offhook_gate: assert property (
      OFFHOOK_REQ_O |-> LINE_READY_O && $past(st_q) == dic_pkg::S_DONE)
      else $error("off-hook before sequence complete");
   a_ready_after: assert property (
      $rose(LINE_READY_O) |->
         $past(DEV_WR_O, 1) && $past(DEV_ADDR_O, 1) == dic_pkg::DEV_LIC_C)
      else $error("ready without complete load");
   // First line byte per country group
   a_lowv_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_LOWV |-> DEV_WDATA_O == 8'h04)
      else $error("low voltage byte wrong");
   a_aus_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_AUS |-> DEV_WDATA_O == 8'h64)
      else $error("australia byte wrong");
   a_plsi_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_PLSI |-> DEV_WDATA_O == 8'h0B)
      else $error("poland group byte wrong");
   a_zaf_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_ZAF |-> DEV_WDATA_O == 8'h4A)
      else $error("south africa byte wrong");
   a_nzl_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_NZL |-> DEV_WDATA_O == 8'h28)
      else $error("new zealand byte wrong");
   a_bgr_byte: assert property (
      lia_wr && profile_q == dic_pkg::PRF_BGR |-> DEV_WDATA_O == 8'h2C)
      else $error("bulgaria group byte wrong");

   // Nothing reaches the device before a start
   a_idle_quiet: assert property (
      st_q == dic_pkg::S_IDLE |-> !DEV_WR_O)
      else $error("device written before start");

   // Main scenarios reached
   c_full_seq: cover property ($rose(LINE_READY_O));
   c_low_volt: cover property (lia_wr && profile_q == dic_pkg::PRF_LOWV);
   c_restart: cover property (LINE_READY_O && start_w);
   c_offhook: cover property ($rose(OFFHOOK_REQ_O));
   c_unmapped: cover property (BVALID_O && BRESP_O == dic_pkg::RESP_SLVERR);
endmodule

/* dic_map_if.sv */
// Carries the chosen profile to the country mapper and the three
// line interface bytes back. Assumes both ends share one clock.
interface dic_map_if;
   logic [2:0] profile;
   logic       acz_opt;
   logic [7:0] lic_a;
   logic [7:0] lic_b;
   logic [7:0] lic_c;
   modport mapper (input profile, acz_opt, output lic_a, lic_b, lic_c);
   modport user   (output profile, acz_opt, input lic_a, lic_b, lic_c);
endinterface

/* dic_pkg.sv */
// Constants for the host-side start-up and country loader of the line
// interface. Assumes one 25 MHz clock and a device register port.
// Notes on behaviour
// - Host writes sample rate first
// - Host waits for PLL lock, 100 us-1 ms
// - Zero to control two powers line side
// - Host then loads country line fields
// - Fields sit in offsets 0x10, 0x11, 0x12
// - European profile: mode 11, limit 1
// - Low-voltage group: dc mode 01 only
// - Australia: onhook speed, ac term, mode 01
// - Poland, Slovenia: mode 10, ringer, threshold
// - South Africa: speed, mode 10, ringer
// - New Zealand: ac term, mode 10
// - Bulgaria group: ac term, mode 11, limit
package dic_pkg;
   // Software register offsets (byte addresses, one word each)
   localparam int        AXI_AW      = 5;
   localparam logic [4:0] OFS_CTRL    = 5'h00;
   localparam logic [4:0] OFS_PROFILE = 5'h04;
   localparam logic [4:0] OFS_SRATE   = 5'h08;
   localparam logic [4:0] OFS_STATUS  = 5'h0C;
   localparam int        CTRL_START  = 0;
   localparam int        CTRL_OFFHK  = 1;
   localparam int        PROF_ACZ    = 3;
   localparam logic [7:0] SRATE_RST   = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Device register addresses
   localparam logic [7:0] DEV_SRATE   = 8'h07;
   localparam logic [7:0] DEV_CTL2    = 8'h06;
   localparam logic [7:0] DEV_LIC_A   = 8'h10;
   localparam logic [7:0] DEV_LIC_B   = 8'h11;
   localparam logic [7:0] DEV_LIC_C   = 8'h12;
   localparam logic [7:0] CTL2_POWER_UP = 8'h00;
   // Field positions in the line interface registers
   localparam int        F_SPD  = 6;
   localparam int        F_ACZ  = 5;
   localparam int        F_DCM  = 2;
   localparam int        F_RGI  = 1;
   localparam int        F_RTH  = 0;
   localparam int        F_ILM  = 0;
   localparam logic [7:0] VADJ_ZERO = 8'h00;
   // Dc termination mode codes
   localparam logic [1:0] DCM_LOWV  = 2'h0;
   localparam logic [1:0] DCM_JAPAN = 2'h1;
   localparam logic [1:0] DCM_FCC   = 2'h2;
   localparam logic [1:0] DCM_CTR   = 2'h3;
   // Country profile codes
   localparam logic [2:0] PRF_NAM   = 3'h0;
   localparam logic [2:0] PRF_CTR   = 3'h1;
   localparam logic [2:0] PRF_LOWV  = 3'h2;
   localparam logic [2:0] PRF_AUS   = 3'h3;
   localparam logic [2:0] PRF_PLSI  = 3'h4;
   localparam logic [2:0] PRF_ZAF   = 3'h5;
   localparam logic [2:0] PRF_NZL   = 3'h6;
   localparam logic [2:0] PRF_BGR   = 3'h7;
   // Lock wait; the longest figure is waited, rounded up
   localparam int CLK_NS      = 40;
   localparam int LOCK_MIN_NS = 100_000;
   localparam int LOCK_MAX_NS = 1_000_000;
   localparam int LOCK_WAIT_CYC = (LOCK_MAX_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {
      S_IDLE, S_SRATE, S_LOCK, S_CTL2, S_LIA, S_LIB, S_LIC, S_DONE
   } dic_state_t;
endpackage

/* testbench.sv */
// Self-checking bench for the start-up sequencer and country loader.
// Assumes the package, design and device model compile first.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LCK = 20;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        dev_wr, line_rdy, offhk, m_pwr, m_rdy;
   logic [7:0]  dev_addr, dev_wdata, m_a, m_b, m_c;
   int          mismatches, comparisons, m_err;
   int          cyc = 0;
   logic [7:0]  wa[$], wd[$];
   int          wc[$];

   dic_init_ctrl #(.LOCK_WAIT_CYC(LCK)) u_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
      .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
      .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .DEV_WR_O(dev_wr), .DEV_ADDR_O(dev_addr),
      .DEV_WDATA_O(dev_wdata), .LINE_READY_O(line_rdy),
      .OFFHOOK_REQ_O(offhk)
   );
   dic_dev_model #(.LOCK_CYC(LCK)) u_dev (
      .clk_i(clk), .rst_n_i(rst_n), .wr_i(dev_wr), .addr_i(dev_addr),
      .wdata_i(dev_wdata), .lic_a_o(m_a), .lic_b_o(m_b), .lic_c_o(m_c),
      .powered_o(m_pwr), .ready_o(m_rdy), .err_o(m_err)
   );

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Log every device write with its cycle number
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (dev_wr) begin
         wa.push_back(dev_addr);
         wd.push_back(dev_wdata);
         wc.push_back(cyc);
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo(input string nm);
      mismatches++;
      $display("[FAIL] %s expected answer seen timeout", nm);
      close_out();
   endtask
   // One write; both channels offered together, released when taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      resp = bresp;
      bready <= 1'b0;
      if (n >= 100) tmo("write answer");
   endtask
   task automatic rdr(input logic [4:0] a);
      int n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 100) tmo("read answer");
   endtask
   // Expected {byte b, byte a}; f is {spd, acz, dc mode, rgi, rth, ilm}
   function automatic logic [15:0] lic(input logic [2:0] p, input logic o);
      logic [6:0] f;
      logic [7:0] a;
      logic [7:0] b;
      case (p)
         dic_pkg::PRF_NAM:  f = 7'h10;
         dic_pkg::PRF_CTR:  f = 7'h19;
         dic_pkg::PRF_LOWV: f = 7'h08;
         dic_pkg::PRF_AUS:  f = 7'h68;
         dic_pkg::PRF_PLSI: f = 7'h16;
         dic_pkg::PRF_ZAF:  f = 7'h54;
         dic_pkg::PRF_NZL:  f = 7'h30;
         default:           f = 7'h39;
      endcase
      a = 8'h00;
      b = 8'h00;
      a[dic_pkg::F_SPD] = f[6];
      a[dic_pkg::F_ACZ] = (p == dic_pkg::PRF_CTR) ? o : f[5];
      a[dic_pkg::F_DCM +: 2] = f[4:3];
      a[dic_pkg::F_RGI] = f[2];
      a[dic_pkg::F_RTH] = f[1];
      b[dic_pkg::F_ILM] = f[0];
      return {b, a};
   endfunction

   initial begin
      logic [2:0]  p;
      logic        o;
      logic [7:0]  sr;
      logic [15:0] ex;
      int          n;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 5'h00;
      araddr = 5'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      rst_n = 1'b0;
      mismatches = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Reset state, register access, refused accesses
      rdr(dic_pkg::OFS_STATUS);
      chk("status", 32'h0, rd);
      chk("powered", 32'h0, 32'(m_pwr));
      rdr(dic_pkg::OFS_SRATE);
      chk("srate reset", 32'(dic_pkg::SRATE_RST), rd);
      wr(dic_pkg::OFS_SRATE, 32'hA5);
      chk("write resp", 32'(dic_pkg::RESP_OKAY), 32'(resp));
      wstrb <= 4'hE;
      wr(dic_pkg::OFS_SRATE, 32'h5A);
      wstrb <= 4'hF;
      rdr(dic_pkg::OFS_SRATE);
      chk("srate", 32'hA5, rd);
      wr(5'h14, 32'h1);
      chk("unmapped write", 32'(dic_pkg::RESP_SLVERR), 32'(resp));
      rdr(5'h10);
      chk("unmapped read", {30'h0, dic_pkg::RESP_SLVERR}, {rd[29:0], resp});
      wr(dic_pkg::OFS_CTRL, 32'h2);
      rdr(dic_pkg::OFS_CTRL);
      chk("ctrl", 32'h2, rd);
      repeat (3) @(posedge clk);
      chk("offhook early", 32'h0, 32'(offhk));
      chk("device writes", 32'h0, wa.size());
      $display("Register test done");
      // Every country profile, then the European one without ac option
      for (int i = 0; i < 9; i++) begin
         p = (i == 8) ? dic_pkg::PRF_CTR : 3'(i);
         o = (i < 8) ? i[0] : 1'b0;
         sr = 8'h30 + 8'(i);
         ex = lic(p, o);
         wr(dic_pkg::OFS_PROFILE, {28'h0, o, p});
         wr(dic_pkg::OFS_SRATE, {24'h0, sr});
         wa.delete();
         wd.delete();
         wc.delete();
         wr(dic_pkg::OFS_CTRL, 32'h3);
         wr(dic_pkg::OFS_PROFILE, {28'h0, ~o, ~p});
         rdr(dic_pkg::OFS_STATUS);
         chk("busy status", 32'h5, {29'h0, rd[2:0]});
         chk("offhook busy", 32'h0, 32'(offhk));
         n = 0;
         while (!line_rdy && n < 200) begin
            @(posedge clk);
            n++;
         end
         if (n >= 200) tmo("line ready");
         chk("write count", 32'h5, wa.size());
         chk("srate wr", {dic_pkg::DEV_SRATE, sr}, {wa[0], wd[0]});
         chk("ctl2 wr", {dic_pkg::DEV_CTL2, dic_pkg::CTL2_POWER_UP},
             {wa[1], wd[1]});
         chk("lock gap", LCK + 1, wc[1] - wc[0]);
         chk("reg a", {dic_pkg::DEV_LIC_A, ex[7:0]}, {wa[2], wd[2]});
         chk("reg b", {dic_pkg::DEV_LIC_B, ex[15:8]}, {wa[3], wd[3]});
         chk("reg c", {dic_pkg::DEV_LIC_C, dic_pkg::VADJ_ZERO},
             {wa[4], wd[4]});
         chk("line gap", 32'h3, wc[4] - wc[1]);
         chk("model regs", {8'h00, dic_pkg::VADJ_ZERO, ex},
             {8'h00, m_c, m_b, m_a});
         chk("model ready", 32'h3, {30'h0, m_pwr, m_rdy});
         chk("model order", 32'h0, m_err);
         repeat (2) @(posedge clk);
         chk("offhook", 32'h1, 32'(offhk));
         rdr(dic_pkg::OFS_STATUS);
         chk("done status", 32'hE, rd);
         $display("Test profile run %0d done", i);
      end
      close_out();
   end
endmodule
